// file: hdl/bridge_pkg.sv
// Shared constants and types of the half-bridge interlock and delay timer
package bridge_pkg;
   localparam int          DEAD_W         = 8;
   localparam int          CNT_W          = 16;
   localparam int          SYNC_STAGES    = 3;
   localparam logic [7:0]  DEAD_ZERO      = 8'h00;
   localparam logic [15:0] CNT_ZERO       = 16'h0000;
   localparam logic [15:0] CNT_MAX        = 16'hffff;
   // Comparator idles high with the stage off; avoids a false edge on release
   localparam logic [2:0]  SYNC_RESET     = 3'h7;

   typedef enum {
      ST_OFF,
      ST_HS_ON,
      ST_LS_ON,
      ST_WAIT_LS,
      ST_WAIT_HS
   } bridge_state_e;

   typedef enum {
      TM_IDLE,
      TM_ON_RUN,
      TM_OFF_RUN
   } timer_state_e;

   typedef struct packed {
      logic [15:0] count;
      logic        switch_on;
      logic        busy;
      logic        valid;
   } delay_result_s;
endpackage : bridge_pkg

// file: hdl/switching_delay_timer.sv
// Switch-on and switch-off latency timer
`timescale 1ns/1ps
module switching_delay_timer (
   input  wire logic                   clk_i,
   input  wire logic                   reset_i,
   input  wire logic                   pwm_channel_control_i,
   input  wire logic                   compare_stable_i,
   input  wire logic                   compare_change_i,
   output bridge_pkg::delay_result_s   result_o
);
   bridge_pkg::timer_state_e state_q;
   logic                     ctrl_q;
   logic [15:0]              count_q;
   logic                     switch_on_q;
   logic                     valid_q;
   logic                     ctrl_rise;
   logic                     ctrl_fall;
   logic                     stop_on;
   logic                     stop_off;

   assign ctrl_rise = pwm_channel_control_i & ~ctrl_q;
   assign ctrl_fall = ~pwm_channel_control_i & ctrl_q;
   // Comparator is the end marker in both directions
   assign stop_on  = compare_change_i & ~compare_stable_i;
   assign stop_off = compare_change_i & compare_stable_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_q <= 1'b0;
      end else begin
         ctrl_q <= pwm_channel_control_i;
      end
   end

   // A new control edge restarts the measurement, aborting one in flight
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q     <= bridge_pkg::TM_IDLE;
         count_q     <= bridge_pkg::CNT_ZERO;
         switch_on_q <= 1'b0;
         valid_q     <= 1'b0;
      end else if (ctrl_rise) begin
         state_q     <= bridge_pkg::TM_ON_RUN;
         count_q     <= bridge_pkg::CNT_ZERO;
         switch_on_q <= 1'b1;
         valid_q     <= 1'b0;
      end else if (ctrl_fall) begin
         state_q     <= bridge_pkg::TM_OFF_RUN;
         count_q     <= bridge_pkg::CNT_ZERO;
         switch_on_q <= 1'b0;
         valid_q     <= 1'b0;
      end else begin
         case (state_q)
            bridge_pkg::TM_ON_RUN,
            bridge_pkg::TM_OFF_RUN: begin
               if ((state_q == bridge_pkg::TM_ON_RUN && stop_on) ||
                   (state_q == bridge_pkg::TM_OFF_RUN && stop_off)) begin
                  state_q <= bridge_pkg::TM_IDLE;
                  valid_q <= 1'b1;
               end else if (count_q != bridge_pkg::CNT_MAX) begin
                  // Saturates rather than wrapping on a missing stop
                  count_q <= count_q + 16'h0001;
               end
            end
            bridge_pkg::TM_IDLE: begin
               state_q <= bridge_pkg::TM_IDLE;
            end
            default: begin
               state_q <= bridge_pkg::TM_IDLE;
            end
         endcase
      end
   end

   // One driver for the whole struct
   assign result_o = {count_q,
                      switch_on_q,
                      state_q != bridge_pkg::TM_IDLE,
                      valid_q};

   a_timer_starts: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ctrl_rise |=> (state_q == bridge_pkg::TM_ON_RUN) && count_q == 16'h0000
      && switch_on_q)
      else $error("Timer did not start on control rise");
   a_timer_holds: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (valid_q && !ctrl_rise && !ctrl_fall) |=> $stable(count_q))
      else $error("Final count changed before next start");
   a_timer_stops: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::TM_OFF_RUN && stop_off && !ctrl_rise
      && !ctrl_fall) |=> valid_q && !switch_on_q)
      else $error("Switch-off measurement did not stop");
   a_timer_on_stops: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::TM_ON_RUN && stop_on && !ctrl_rise
      && !ctrl_fall) |=> valid_q && switch_on_q)
      else $error("Switch-on measurement did not stop");
endmodule : switching_delay_timer

// file: hdl/bridge_interlock.sv
// Half-bridge cross-conduction interlock with switching delay measurement
// Operation
// - Low-side turn-on right after high-side off waits the cross-conduction time.
// - After that time the gated low-side on signal goes to the driver.
// - High-side fast discharge is asserted while low-side is held back.
// - After protection ends the parallel discharge path is enabled.
// - Driver switches on when the channel control goes low to high; the gates here follow the on requests, the control only starts the timer.
// - Driver switches off when the channel control goes high to low; the gates here follow the on requests, the control only starts the timer.
// - Switch-on timing starts on the control rising edge.
// - Switch-on timing stops on the comparator falling edge.
// - Switch-off timing starts on the control falling edge.
// - Switch-off timing stops on the comparator rising edge.
// - The comparator output marks the end of every measurement.
// - Cross-conduction time comes from a user programmable dead counter.
// - Gated low-side on is the low request masked by the interlock.
`timescale 1ns/1ps
module bridge_interlock #(
   parameter int DEAD_W = bridge_pkg::DEAD_W
) (
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 high_side_on_request_i,
   input  wire logic                 low_side_on_request_i,
   input  wire logic [DEAD_W-1:0]    dead_time_cycles_i,
   input  wire logic                 pwm_channel_control_i,
   input  wire logic                 drain_source_compare_out_i,
   output logic                      high_side_on_gated_o,
   output logic                      low_side_on_gated_o,
   output logic                      high_side_fast_discharge_o,
   output logic                      low_side_fast_discharge_o,
   output logic                      high_side_parallel_discharge_o,
   output logic                      low_side_parallel_discharge_o,
   output bridge_pkg::delay_result_s switching_delay_timer_o
);
   bridge_pkg::bridge_state_e state_q;
   bridge_pkg::bridge_state_e state_d;
   logic [DEAD_W-1:0]         dead_q;
   logic [DEAD_W-1:0]         dead_d;
   logic [2:0]                sync_q;
   logic                      cmp_stable_q;
   logic                      cmp_change;
   logic                      hs_req;
   logic                      ls_req;
   bridge_pkg::delay_result_s timer_res;
   logic [DEAD_W:0]           wait_len_q;
   logic [DEAD_W-1:0]         wait_load_q;

   assign hs_req = high_side_on_request_i;
   assign ls_req = low_side_on_request_i;

   // Off-going side always passes a wait state so the dead counter runs
   always_comb begin
      state_d = state_q;
      dead_d  = dead_q;
      if (dead_q != '0) begin
         dead_d = dead_q - DEAD_W'(1);
      end
      case (state_q)
         bridge_pkg::ST_OFF: begin
            if (hs_req && !ls_req) begin
               state_d = bridge_pkg::ST_HS_ON;
            end else if (ls_req && !hs_req) begin
               state_d = bridge_pkg::ST_LS_ON;
            end
         end
         bridge_pkg::ST_HS_ON: begin
            if (!hs_req) begin
               state_d = bridge_pkg::ST_WAIT_LS;
               dead_d  = dead_time_cycles_i;
            end
         end
         bridge_pkg::ST_LS_ON: begin
            if (!ls_req) begin
               state_d = bridge_pkg::ST_WAIT_HS;
               dead_d  = dead_time_cycles_i;
            end
         end
         bridge_pkg::ST_WAIT_LS: begin
            if (dead_q == '0) begin
               state_d = (ls_req && !hs_req) ? bridge_pkg::ST_LS_ON
                                             : bridge_pkg::ST_OFF;
            end
         end
         bridge_pkg::ST_WAIT_HS: begin
            if (dead_q == '0) begin
               state_d = (hs_req && !ls_req) ? bridge_pkg::ST_HS_ON
                                             : bridge_pkg::ST_OFF;
            end
         end
         default: begin
            state_d = bridge_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= bridge_pkg::ST_OFF;
         dead_q  <= '0;
      end else begin
         state_q <= state_d;
         dead_q  <= dead_d;
      end
   end

   // Outputs registered from the next state to keep them glitch free
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         high_side_on_gated_o       <= 1'b0;
         low_side_on_gated_o        <= 1'b0;
         high_side_fast_discharge_o <= 1'b0;
         low_side_fast_discharge_o  <= 1'b0;
      end else begin
         high_side_on_gated_o <= (state_d == bridge_pkg::ST_HS_ON);
         low_side_on_gated_o  <= (state_d == bridge_pkg::ST_LS_ON);
         high_side_fast_discharge_o <=
            (state_d == bridge_pkg::ST_WAIT_LS) && ls_req;
         low_side_fast_discharge_o  <=
            (state_d == bridge_pkg::ST_WAIT_HS) && hs_req;
      end
   end

   // Parallel path stays on until that side is driven on again
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         high_side_parallel_discharge_o <= 1'b0;
         low_side_parallel_discharge_o  <= 1'b0;
      end else begin
         if (state_d == bridge_pkg::ST_HS_ON) begin
            high_side_parallel_discharge_o <= 1'b0;
         end else if (state_q == bridge_pkg::ST_WAIT_LS &&
                      state_d != bridge_pkg::ST_WAIT_LS) begin
            high_side_parallel_discharge_o <= 1'b1;
         end
         if (state_d == bridge_pkg::ST_LS_ON) begin
            low_side_parallel_discharge_o <= 1'b0;
         end else if (state_q == bridge_pkg::ST_WAIT_HS &&
                      state_d != bridge_pkg::ST_WAIT_HS) begin
            low_side_parallel_discharge_o <= 1'b1;
         end
      end
   end

   // Comparator is asynchronous; edge accepted once stages two and three agree
   assign cmp_change = (sync_q[1] == sync_q[2]) && (sync_q[2] != cmp_stable_q);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync_q       <= bridge_pkg::SYNC_RESET;
         cmp_stable_q <= bridge_pkg::SYNC_RESET[2];
      end else begin
         sync_q <= {sync_q[1:0], drain_source_compare_out_i};
         if (cmp_change) begin
            cmp_stable_q <= sync_q[2];
         end
      end
   end

   switching_delay_timer u_timer (
      .clk_i                 (clk_i),
      .reset_i               (reset_i),
      .pwm_channel_control_i (pwm_channel_control_i),
      .compare_stable_i      (sync_q[2]),
      .compare_change_i      (cmp_change),
      .result_o              (timer_res)
   );

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         switching_delay_timer_o <= '0;
      end else begin
         switching_delay_timer_o <= timer_res;
      end
   end

   // Independent count of wait cycles, so the dead counter's pace is checked
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wait_len_q  <= '0;
         wait_load_q <= '0;
      end else if (state_q == bridge_pkg::ST_HS_ON ||
                   state_q == bridge_pkg::ST_LS_ON) begin
         wait_len_q  <= '0;
         wait_load_q <= dead_time_cycles_i;
      end else if (wait_len_q != '1) begin
         wait_len_q <= wait_len_q + 1'b1;
      end
   end

   a_no_cross_on: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !(high_side_on_gated_o && low_side_on_gated_o))
      else $error("Both gates driven on");
   a_ls_held_back: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_HS_ON && !hs_req && ls_req
      && dead_time_cycles_i == 8'h05) |=> !low_side_on_gated_o [*6])
      else $error("Low side released before dead time");
   a_hs_held_back: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_LS_ON && !ls_req && hs_req
      && dead_time_cycles_i == 8'h02) |=> !high_side_on_gated_o [*3])
      else $error("High side released before dead time");
   a_ls_released: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_WAIT_LS && dead_q == '0 && ls_req && !hs_req)
      |=> low_side_on_gated_o)
      else $error("Low side not released after dead time");
   a_hs_released: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_WAIT_HS && dead_q == '0 && hs_req && !ls_req)
      |=> high_side_on_gated_o)
      else $error("High side not released after dead time");
   // Output lags the request by one cycle, so the request must be steady
   a_fast_discharge: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_WAIT_LS && dead_q != '0 && ls_req
      && $past(ls_req)) |-> high_side_fast_discharge_o)
      else $error("Fast discharge missing while held back");
   a_ls_fast_discharge: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_WAIT_HS && dead_q != '0 && hs_req
      && $past(hs_req)) |-> low_side_fast_discharge_o)
      else $error("Low side fast discharge missing while held back");
   // A request dropped mid-wait also ends fast discharge; not the end of wait
   a_parallel_after: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $fell(high_side_fast_discharge_o) && !high_side_on_gated_o
      && state_q != bridge_pkg::ST_WAIT_LS |-> high_side_parallel_discharge_o)
      else $error("Parallel discharge not enabled after protection");
   a_gate_on_rise: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_OFF && hs_req && !ls_req)
      |=> high_side_on_gated_o)
      else $error("Gate not switched on after request rise");
   a_gate_off_fall: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (high_side_on_gated_o && !hs_req) |=> !high_side_on_gated_o)
      else $error("Gate not switched off after request fall");
   a_dead_time_len: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state_q == bridge_pkg::ST_WAIT_LS ||
       state_q == bridge_pkg::ST_WAIT_HS) && dead_q == '0
      |-> wait_len_q == {1'b0, wait_load_q})
      else $error("Dead time wait has the wrong length");
endmodule : bridge_interlock

// file: test/bridge_stage_model.sv
// Behavioural half-bridge stage giving the drain-source comparator output
`timescale 1ns/1ps
module bridge_stage_model (
   input  wire logic       clk_i,
   input  wire logic       ctrl_i,
   input  wire logic [7:0] lag_i,
   output logic            cmp_o
);
   logic [7:0] wait_q;
   logic       settled_q;

   initial begin
      cmp_o     = 1'b1;
      settled_q = 1'b0;
      wait_q    = 8'h00;
   end

   // Comparator low while switched on, high while off; lag is switching time
   always @(posedge clk_i) begin
      if (ctrl_i == settled_q) begin
         wait_q <= 8'h00;
      end else if (wait_q >= lag_i) begin
         settled_q <= ctrl_i;
         cmp_o     <= ~ctrl_i;
         wait_q    <= 8'h00;
      end else begin
         wait_q <= wait_q + 8'h01;
      end
   end
endmodule : bridge_stage_model

// file: test/bridge_interlock_tb.sv
// Self-checking bench of the half-bridge interlock and delay timer
`timescale 1ns/1ps
module bridge_interlock_tb;
   logic                      clk_i;
   logic                      reset_i;
   logic                      hs_req;
   logic                      ls_req;
   logic [7:0]                dead;
   logic                      ctrl;
   logic [7:0]                lag;
   logic                      cmp;
   logic                      hs_on;
   logic                      ls_on;
   logic                      hs_fd;
   logic                      ls_fd;
   logic                      hs_par;
   logic                      ls_par;
   bridge_pkg::delay_result_s res;
   int                        fails;
   int                        n_checks;
   int                        cyc;
   logic [15:0]               cnt[4];

   bridge_interlock uut (
      .clk_i                          (clk_i),
      .reset_i                        (reset_i),
      .high_side_on_request_i         (hs_req),
      .low_side_on_request_i          (ls_req),
      .dead_time_cycles_i             (dead),
      .pwm_channel_control_i          (ctrl),
      .drain_source_compare_out_i     (cmp),
      .high_side_on_gated_o           (hs_on),
      .low_side_on_gated_o            (ls_on),
      .high_side_fast_discharge_o     (hs_fd),
      .low_side_fast_discharge_o      (ls_fd),
      .high_side_parallel_discharge_o (hs_par),
      .low_side_parallel_discharge_o  (ls_par),
      .switching_delay_timer_o        (res)
   );

   bridge_stage_model stage (
      .clk_i  (clk_i),
      .ctrl_i (ctrl),
      .lag_i  (lag),
      .cmp_o  (cmp)
   );

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // Hang guard, well above the under one thousand cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   // One side on, then hand over to the other with dead time n
   task automatic t_swap(input logic hs_first, input logic [7:0] n);
      dead   = n;
      hs_req = hs_first;
      ls_req = ~hs_first;
      step(2);
      check({hs_on, ls_on}, {hs_first, ~hs_first});
      check(hs_first ? hs_par : ls_par, 1'h0);
      hs_req = ~hs_first;
      ls_req = hs_first;
      // Wait shows from the first edge after the swap, for n+1 cycles
      step(1);
      for (int k = 0; k <= int'(n); k++) begin
         check({hs_on, ls_on}, 2'h0);
         check(hs_first ? hs_fd : ls_fd, 1'h1);
         step(1);
      end
      check({hs_on, ls_on}, {~hs_first, hs_first});
      check({hs_fd, ls_fd}, 2'h0);
      check(hs_first ? hs_par : ls_par, 1'h1);
      hs_req = 1'b0;
      ls_req = 1'b0;
      step(int'(n) + 4);
      check({hs_on, ls_on}, 2'h0);
      $display("test swap hs_first=%0d dead=%0d done", hs_first, n);
   endtask : t_swap

   // Both requests at once must never drive either gate
   task automatic t_both_high;
      hs_req = 1'b1;
      ls_req = 1'b1;
      for (int k = 0; k < 6; k++) begin
         step(1);
         check({hs_on, ls_on}, 2'h0);
      end
      hs_req = 1'b0;
      ls_req = 1'b0;
      step(2);
      $display("test both_high done");
   endtask : t_both_high

   // One control edge with switching lag l; returns measured count
   task automatic t_measure(input logic lvl, input logic [7:0] l,
                            output logic [15:0] c);
      int k;
      lag  = l;
      ctrl = lvl;
      step(3);
      check({res.busy, res.valid}, 2'h2);
      check(res.switch_on, lvl);
      k = 0;
      while (res.valid !== 1'b1 && k < 200) begin
         step(1);
         k++;
      end
      check(res.valid, 1'h1);
      c = res.count;
      step(8);
      check({res.count, res.valid}, {c, 1'h1});
      $display("test measure lvl=%0d lag=%0d count=%0d", lvl, l, c);
   endtask : t_measure

   initial begin
      fails    = 0;
      n_checks = 0;
      cyc      = 0;
      reset_i  = 1'b1;
      hs_req   = 1'b0;
      ls_req   = 1'b0;
      dead     = 8'h00;
      ctrl     = 1'b0;
      lag      = 8'h04;
      step(16);
      reset_i = 1'b0;
      check({hs_on, ls_on}, 2'h0);
      check({hs_fd, ls_fd, hs_par, ls_par}, 4'h0);
      check(res.valid, 1'h0);
      t_swap(1'b1, 8'h00);
      t_swap(1'b1, 8'h05);
      t_swap(1'b0, 8'h02);
      t_swap(1'b0, 8'hff);
      t_both_high();
      t_measure(1'b1, 8'h04, cnt[0]);
      t_measure(1'b0, 8'h04, cnt[1]);
      t_measure(1'b1, 8'h0a, cnt[2]);
      t_measure(1'b0, 8'h0a, cnt[3]);
      // Absolute sync latency is open, so compare differences of lag
      check(cnt[2] - cnt[0], 16'h0006);
      check(cnt[3] - cnt[1], 16'h0006);
      report_and_stop();
   end
endmodule : bridge_interlock_tb
